// file: pdc_top.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pdc_top
  import pdc_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // System bus memory access
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [1:0]  mem_be,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata,
  // System bus I/O read of error status
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_addr,
  output logic             io_hit,
  output logic [15:0]      io_rdata,
  // DRAM array
  output logic             dram_cyc,
  output logic             dram_refresh,
  output logic             dram_we,
  output logic [1:0]       dram_be,
  output logic             dram_bank,
  output logic [ROW_W-1:0] dram_row,
  output logic [COL_W-1:0] dram_col,
  output logic [17:0]      dram_wdata,
  input  wire logic [17:0] dram_rdata,
  // Board pins
  input  wire logic        mem_protect_n,
  output logic             err_led,
  output logic             irq
);
  pdc_par_if par ();

  pdc_parity u_par (
    .p (par)
  );

  pdc_state_t       st_r;
  logic [7:0]       tmr_r;
  logic             ref_pend_r;
  logic [ROW_W-1:0] ref_row_r;
  logic [2:0]       cnt_r;
  logic             prot_s1_r;
  logic             prot_s2_r;
  logic             odd_r;
  logic [11:0]      base_r;
  logic [4:0]       ioport_r;
  logic [1:0]       status_r;
  logic [1:0]       mask_r;
  logic [10:0]      err_r;
  logic [17:0]      cap_r;
  logic             rd_op_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic [15:0]      io_rdata_r;
  logic [11:0]      page_off;
  logic             win_hit;
  logic             blocked;
  logic             start_acc;
  logic             perr_evt;
  logic             prot_evt;
  logic             apb_wr;
  logic             apb_setup;

  // Address window decode on 4K pages
  assign page_off = mem_addr[23:12] - base_r;
  assign win_hit  = (mem_addr[23:12] >= base_r) &&
                    (page_off < WIN_PAGES);
  // Window placement across megabytes is the integrator's job
  assign blocked   = ~prot_s2_r;
  assign start_acc = (st_r == ST_IDLE) && !ref_pend_r && mem_req && win_hit;

  // Parity unit operands: write data at start, captured data on check
  assign par.odd    = odd_r;
  assign par.data   = (st_r == ST_DONE) ? cap_r[15:0] : mem_wdata;
  assign par.stored = cap_r[17:16];

  // Events for the status register
  // Read flag is taken at acceptance, so a pin change mid-cycle is harmless
  assign perr_evt = (st_r == ST_DONE) && rd_op_r &&
                    (|(par.err & dram_be));
  assign prot_evt = start_acc && blocked;

  // Protect pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_s1_r <= 1'b1;
      prot_s2_r <= 1'b1;
    end else begin
      prot_s1_r <= mem_protect_n;
      prot_s2_r <= prot_s1_r;
    end
  end

  // Refresh interval timer; pending flag survives a busy host cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r      <= 8'h00;
      ref_pend_r <= 1'b0;
    end else begin
      if (tmr_r == 8'(REF_INT_CYC - 1)) begin
        tmr_r      <= 8'h00;
        ref_pend_r <= 1'b1;
      end else begin
        tmr_r <= tmr_r + 8'h01;
        if (st_r == ST_IDLE && ref_pend_r) begin
          ref_pend_r <= 1'b0;
        end
      end
    end
  end

  // Array sequencer; refresh wins when both are waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_IDLE;
      cnt_r     <= 3'h0;
      ref_row_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          cnt_r <= 3'h0;
          if (ref_pend_r) begin
            st_r <= ST_REFRESH;
          end else if (start_acc) begin
            st_r <= blocked ? ST_DONE : ST_ACCESS;
          end
        end
        ST_REFRESH: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(REF_CYC - 1)) begin
            st_r      <= ST_IDLE;
            ref_row_r <= ref_row_r + 1'b1;
          end
        end
        ST_ACCESS: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(ACC_CYC - 1)) begin
            st_r <= ST_DONE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Array drive, latched when a host access is accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_we    <= 1'b0;
      dram_be    <= 2'h0;
      dram_bank  <= 1'b0;
      dram_col   <= '0;
      dram_wdata <= 18'h00000;
      rd_op_r    <= 1'b0;
    end else if (start_acc) begin
      dram_we    <= mem_we && !blocked;
      dram_be    <= mem_be;
      dram_bank  <= page_off[4];
      dram_col   <= mem_addr[7:1];
      dram_wdata <= {par.gen, mem_wdata};
      rd_op_r    <= !mem_we && !blocked;
    end
  end

  // Row comes from the refresh counter during refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_row <= '0;
    end else if (st_r == ST_IDLE && ref_pend_r) begin
      dram_row <= ref_row_r;
    end else if (start_acc) begin
      dram_row <= {page_off[3:0], mem_addr[11:8]};
    end
  end

  // Cycle strobes follow the sequencer state
  assign dram_cyc     = (st_r == ST_REFRESH) || (st_r == ST_ACCESS);
  assign dram_refresh = (st_r == ST_REFRESH);

  // Read data capture at the end of the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= 18'h00000;
    end else if (st_r == ST_ACCESS && cnt_r == 3'(ACC_CYC - 1)) begin
      cap_r <= dram_rdata;
    end else if (start_acc) begin
      cap_r <= 18'h00000;                       // Blocked reads return zero
    end
  end

  // Host answer: acknowledge withheld until the sequencer finishes
  assign mem_ack   = (st_r == ST_DONE);
  assign mem_rdata = cap_r[15:0];

  // Error capture: row, bank and failing lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 11'h000;
    end else if (perr_evt) begin
      err_r <= {par.err & dram_be, dram_bank, dram_row};
    end
  end

  // Sticky status; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 2'h0;
    end else begin
      status_r[ST_PERR] <= perr_evt ||
        (status_r[ST_PERR] && !(apb_wr && paddr == OFF_STATUS &&
                                pwdata[ST_PERR]));
      status_r[ST_PROT] <= prot_evt ||
        (status_r[ST_PROT] && !(apb_wr && paddr == OFF_STATUS &&
                                pwdata[ST_PROT]));
    end
  end

  assign irq     = |(status_r & mask_r);
  assign err_led = status_r[ST_PERR];

  // APB control registers
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odd_r    <= 1'b0;
      base_r   <= BASE_RST;
      ioport_r <= IOPORT_RST;
      mask_r   <= MASK_RST;
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        odd_r <= pwdata[CTRL_ODD];
      end else if (paddr == OFF_BASE) begin
        base_r <= pwdata[11:0];
      end else if (paddr == OFF_IOPORT) begin
        ioport_r <= pwdata[4:0];
      end else if (paddr == OFF_MASK) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // Read data registered in the setup cycle so the access ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      pslverr_r <= 1'b0;
      if (paddr == OFF_CTRL) begin
        prdata_r <= {31'h00000000, odd_r};
      end else if (paddr == OFF_BASE) begin
        prdata_r <= {20'h00000, base_r};
      end else if (paddr == OFF_IOPORT) begin
        prdata_r <= {27'h0000000, ioport_r};
      end else if (paddr == OFF_STATUS) begin
        prdata_r <= {30'h00000000, status_r};
      end else if (paddr == OFF_MASK) begin
        prdata_r <= {30'h00000000, mask_r};
      end else if (paddr == OFF_ERR) begin
        prdata_r <= {21'h000000, err_r};
      end else if (paddr == OFF_STATE) begin
        prdata_r <= {27'h0000000, ref_pend_r, st_r, prot_s2_r, odd_r};
      end else begin
        prdata_r  <= 32'h00000000;
        pslverr_r <= 1'b1;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // System-bus I/O port; only the low nibble is free inside a range
  assign io_hit = io_rd && (io_addr[3:0] == ioport_r[3:0]) &&
                  (io_addr[7:4] == (ioport_r[IOP_HIGH] ? IO_HIGH_HI
                                                       : IO_LOW_HI));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_rdata_r <= 16'h0000;
    end else if (io_hit) begin
      io_rdata_r <= {5'h00, err_r};
    end
  end

  assign io_rdata = io_rdata_r;
endmodule
`default_nettype wire

// file: pdc_pkg.sv
`default_nettype none
package pdc_pkg;
  // Clock and timing
  localparam int CLK_NS      = 100;
  localparam int REF_INT_NS  = 14000;
  localparam int REF_MAX_NS  = 480;
  localparam int ACC_NS      = 300;
  localparam int REF_INT_CYC = (REF_INT_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC     = (REF_MAX_NS / CLK_NS < 1) ? 1 : REF_MAX_NS / CLK_NS;
  localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;

  // Array geometry: 64K words of 16 bits, 128K bytes
  localparam int ROW_W       = 8;
  localparam int COL_W       = 7;
  localparam logic [11:0] WIN_PAGES = 12'h020;

  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BASE   = 8'h04;
  localparam logic [7:0] OFF_IOPORT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_ERR    = 8'h14;
  localparam logic [7:0] OFF_STATE  = 8'h18;

  // Field positions
  localparam int CTRL_ODD    = 0;
  localparam int ST_PERR     = 0;
  localparam int ST_PROT     = 1;
  localparam int IOP_HIGH    = 4;

  // Reset values
  localparam logic [11:0] BASE_RST   = 12'h000;
  localparam logic [4:0]  IOPORT_RST = 5'h00;
  localparam logic [1:0]  MASK_RST   = 2'h0;

  // I/O port ranges
  localparam logic [3:0] IO_LOW_HI  = 4'h0;
  localparam logic [3:0] IO_HIGH_HI = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REFRESH,
    ST_ACCESS,
    ST_DONE
  } pdc_state_t;
endpackage
`default_nettype wire

// file: pdc_par_if.sv
`timescale 1ns/1ps
`default_nettype none
// Parity path between the controller and its parity unit
interface pdc_par_if;
  logic [15:0] data;
  logic        odd;
  logic [1:0]  stored;
  logic [1:0]  gen;
  logic [1:0]  err;
  modport ctl (output data, output odd, output stored, input gen, input err);
  modport unit (input data, input odd, input stored, output gen, output err);
endinterface
`default_nettype wire

// file: pdc_parity.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_parity (
  pdc_par_if.unit p
);
  // One parity bit per byte; odd sense inverts it
  function automatic logic byte_par(input logic [7:0] b, input logic odd);
    byte_par = (^b) ^ odd;
  endfunction

  // Generation for writes
  assign p.gen[0] = byte_par(p.data[7:0], p.odd);
  assign p.gen[1] = byte_par(p.data[15:8], p.odd);

  // Recompute on reads and compare with stored bits
  assign p.err[0] = byte_par(p.data[7:0], p.odd) != p.stored[0];
  assign p.err[1] = byte_par(p.data[15:8], p.odd) != p.stored[1];
endmodule
`default_nettype wire

// file: pdc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_props
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Host side and pins
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic        io_rd,
  input wire logic [7:0]  io_addr,
  input wire logic        io_hit,
  input wire logic        mem_protect_n,
  input wire logic        err_led,
  input wire logic        irq,
  // Array side
  input wire logic        dram_cyc,
  input wire logic        dram_refresh,
  input wire logic        dram_we,
  input wire logic [1:0]  dram_be,
  input wire logic [17:0] dram_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic      odd_r;
  wire logic wr_w = psel && penable && pwrite;
  // Shadow of the sense bit, so write parity can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      odd_r <= 1'h0;
    else if (wr_w && paddr == OFF_CTRL)
      odd_r <= pwdata[CTRL_ODD];
  end
  property p_ref_len;
    $rose(dram_refresh) |-> dram_refresh[*4] ##1 !dram_refresh;
  endproperty
  a_ref_len: assert property (p_ref_len) else $error("refresh length");
  property p_ref_per;
    $fell(dram_refresh) |-> ##[120:150] $rose(dram_refresh);
  endproperty
  a_ref_per: assert property (p_ref_per) else $error("refresh period");
  property p_ref_excl;
    dram_refresh |-> !mem_ack;
  endproperty
  a_ref_excl: assert property (p_ref_excl) else $error("ack in refresh");
  property p_ack_req;
    mem_ack |-> mem_req ##1 !mem_ack;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("stray ack");
  property p_prot;
    !mem_protect_n [*6] |-> !(dram_cyc && dram_we && !dram_refresh);
  endproperty
  a_prot: assert property (p_prot) else $error("write while protected");
  // Lane 0 parity sits in bit 16
  property p_par;
    dram_cyc && dram_we && !dram_refresh && dram_be[0]
      |-> dram_wdata[16] == (^dram_wdata[7:0] ^ odd_r);
  endproperty
  a_par: assert property (p_par) else $error("write parity");
  property p_led;
    $rose(err_led) |-> $past(mem_ack && !mem_we);
  endproperty
  a_led: assert property (p_led) else $error("led without read");
  property p_irq;
    $rose(irq) |-> $past(mem_req) || $past(wr_w);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_io;
    io_hit |-> io_rd && (io_addr[7:4] == IO_LOW_HI || io_addr[7:4] == IO_HIGH_HI);
  endproperty
  a_io: assert property (p_io) else $error("io decode");
  c_perr: cover property ($rose(err_led));
  c_prot: cover property (mem_ack && !mem_protect_n);
  c_ref: cover property ($fell(dram_refresh));
endmodule
`default_nettype wire

// file: pdc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural array: one 18-bit word per bank, row and column
module pdc_dram_model (
  // Clock
  input wire logic        pclk,
  // Array control
  input wire logic        dram_cyc,
  input wire logic        dram_refresh,
  input wire logic        dram_we,
  input wire logic [1:0]  dram_be,
  input wire logic        dram_bank,
  input wire logic [7:0]  dram_row,
  input wire logic [6:0]  dram_col,
  input wire logic [17:0] dram_wdata,
  output logic [17:0]     dram_rdata
);
  logic [17:0] mem [0:65535];
  logic [17:0] last_r = 18'h00000;
  wire logic [15:0] idx = {dram_bank, dram_row, dram_col};
  wire logic        rd_w = dram_cyc && !dram_we && !dram_refresh;
  // Each lane keeps its byte with its own parity bit
  always @(posedge pclk) begin
    if (dram_cyc && dram_we && !dram_refresh && dram_be[0])
      mem[idx][16] <= dram_wdata[16];
    if (dram_cyc && dram_we && !dram_refresh && dram_be[0])
      mem[idx][7:0] <= dram_wdata[7:0];
    if (dram_cyc && dram_we && !dram_refresh && dram_be[1])
      mem[idx][17] <= dram_wdata[17];
    if (dram_cyc && dram_we && !dram_refresh && dram_be[1])
      mem[idx][15:8] <= dram_wdata[15:8];
    if (rd_w)
      last_r <= dram_rdata;
  end
  // Unselected data lines flip, so a stale word never passes as fresh
  assign dram_rdata = rd_w ? mem[idx] : ~last_r;
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pdc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        mem_req, mem_we, mem_ack, io_rd, io_hit, mem_protect_n;
  logic        err_led, irq, dram_cyc, dram_refresh, dram_we, dram_bank;
  logic [1:0]  mem_be, dram_be;
  logic [6:0]  dram_col;
  logic [7:0]  paddr, io_addr, dram_row;
  logic [15:0] mem_wdata, mem_rdata, io_rdata, md;
  logic [17:0] dram_wdata, dram_rdata;
  logic [23:0] mem_addr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors = 0;
  int          n_checks = 0;
  pdc_top pdc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
    .mem_be, .mem_wdata, .mem_ack, .mem_rdata, .io_rd, .io_addr, .io_hit,
    .io_rdata, .dram_cyc, .dram_refresh, .dram_we, .dram_be, .dram_bank,
    .dram_row, .dram_col, .dram_wdata, .dram_rdata, .mem_protect_n,
    .err_led, .irq);
  pdc_dram_model pdc_dram_model_inst (.pclk, .dram_cyc, .dram_refresh,
    .dram_we, .dram_be, .dram_bank, .dram_row, .dram_col, .dram_wdata,
    .dram_rdata);
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic to_fail(input string m);
    n_errors++;
    $display("mismatch at %0t: no answer on %s", $time, m);
    tally_and_finish();
  endtask
  // One APB transfer; the request stands until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
      to_fail("apb");
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One host access; the request is held until the acknowledge
  task automatic mem(input logic w, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    mem_req <= 1'h1;
    mem_we <= w;
    mem_addr <= a;
    mem_wdata <= d;
    do begin
      @(posedge pclk);
      n++;
    end while (mem_ack !== 1'h1 && n < 30);
    if (mem_ack !== 1'h1)
      to_fail("mem");
    md = mem_rdata;
    mem_req <= 1'h0;
  endtask
  task automatic t_regs();
    apb(1'h0, OFF_MASK, 32'h0);
    chk(rd, 32'h0, "mask reset");
    apb(1'h0, 8'h1C, 32'h0);
    chk(se, 1'h1, "unmapped");
    apb(1'h1, OFF_BASE, 32'h010);
    apb(1'h0, OFF_BASE, 32'h0);
    chk(rd, 32'h010, "base");
    apb(1'h0, OFF_STATE, 32'h0);
    chk(rd[1:0], 2'h2, "state sync");
    $display("test regs done");
  endtask
  task automatic t_rw();
    mem(1'h1, 24'h010100, 16'h1234);
    mem(1'h1, 24'h022300, 16'hA55A);
    mem(1'h0, 24'h010100, 16'h0);
    chk(md, 16'h1234, "read back");
    mem(1'h0, 24'h022300, 16'h0);
    chk(md, 16'hA55A, "read back");
    mem(1'h1, 24'h010102, 16'h5678);
    mem_be <= 2'h2;
    mem(1'h1, 24'h010102, 16'hAB00);
    mem_be <= 2'h3;
    mem(1'h0, 24'h010102, 16'h0);
    chk(md, 16'hAB78, "byte lane");
    chk(err_led, 1'h0, "no error");
    $display("test rw done");
  endtask
  task automatic t_perr();
    apb(1'h1, OFF_MASK, 32'h1);
    apb(1'h1, OFF_CTRL, 32'h1);
    mem(1'h0, 24'h022300, 16'h0);
    @(posedge pclk);
    chk(err_led, 1'h1, "led");
    chk(irq, 1'h1, "irq");
    apb(1'h0, OFF_ERR, 32'h0);
    chk(rd[10:0], 11'h723, "row bank");
    apb(1'h1, OFF_IOPORT, 32'h15);
    io_addr <= 8'h45;
    io_rd <= 1'h1;
    @(posedge pclk);
    chk(io_hit, 1'h1, "io hit");
    io_addr <= 8'h05;
    @(posedge pclk);
    chk(io_hit, 1'h0, "io miss");
    chk(io_rdata, 16'h0723, "io data");
    apb(1'h1, OFF_IOPORT, 32'h05);
    @(posedge pclk);
    chk(io_hit, 1'h1, "io low");
    io_rd <= 1'h0;
    apb(1'h1, OFF_MASK, 32'h0);
    @(posedge pclk);
    chk(irq, 1'h0, "masked");
    apb(1'h1, OFF_STATUS, 32'h3);
    @(posedge pclk);
    chk(err_led, 1'h0, "cleared");
    apb(1'h1, OFF_CTRL, 32'h0);
    $display("test parity done");
  endtask
  task automatic t_prot();
    apb(1'h1, OFF_MASK, 32'h2);
    mem_protect_n <= 1'h0;
    repeat (3) @(posedge pclk);
    mem(1'h1, 24'h010100, 16'hBEEF);
    mem(1'h0, 24'h010100, 16'h0);
    chk(md, 16'h0, "blocked read");
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[1:0], 2'h2, "blocked flag");
    chk(irq, 1'h1, "protect irq");
    mem_protect_n <= 1'h1;
    repeat (3) @(posedge pclk);
    mem(1'h0, 24'h010100, 16'h0);
    chk(md, 16'h1234, "kept data");
    apb(1'h1, OFF_STATUS, 32'h2);
    @(posedge pclk);
    chk(irq, 1'h0, "protect clear");
    $display("test protect done");
  endtask
  task automatic t_ref();
    int n;
    int h;
    n = 0;
    h = 0;
    // Skip a refresh that a host cycle may have pushed late
    while (dram_refresh === 1'h1 && h < 10) begin
      @(posedge pclk);
      h++;
    end
    while (dram_refresh !== 1'h1 && h < 300) begin
      @(posedge pclk);
      h++;
    end
    h = 0;
    while (dram_refresh === 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
      h++;
    end
    while (dram_refresh !== 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
      to_fail("refresh");
    chk(n, REF_INT_NS / CLK_NS, "period");
    chk(h, REF_MAX_NS / CLK_NS, "length");
    mem(1'h0, 24'h010100, 16'h0);
    chk(md, 16'h1234, "held off");
    chk(dram_refresh, 1'h0, "ack after refresh");
    $display("test refresh done");
  endtask
  initial begin
    {psel, penable, pwrite, mem_req, mem_we, io_rd} = 6'h00;
    {paddr, io_addr, pwdata, mem_addr, mem_wdata} = 88'h0;
    mem_be = 2'h3;
    mem_protect_n = 1'h1;
    presetn = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_rw();
    t_perr();
    t_prot();
    t_ref();
    tally_and_finish();
  end
endmodule
bind pdc_top pdc_props pdc_props_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .mem_req, .mem_we, .mem_ack, .io_rd, .io_addr,
  .io_hit, .mem_protect_n, .err_led, .irq, .dram_cyc, .dram_refresh,
  .dram_we, .dram_be, .dram_wdata);
`default_nettype wire
